// [design/sltrg_pkg.sv]
// sltrg_pkg: constants, types and register map of the sample level trigger.
// assumes a 32-bit apb slave at 20 mhz and 24-bit signed samples.
package sltrg_pkg;
  localparam int          SLTRG_NCH       = 8;
  localparam int          SLTRG_SW        = 24;
  localparam int          SLTRG_NLINES    = 8;
  localparam int          SLTRG_RSV_LINE  = 5;
  localparam logic [11:0] SLTRG_A_CTRL    = 12'h000;
  localparam logic [11:0] SLTRG_A_LOW     = 12'h004;
  localparam logic [11:0] SLTRG_A_HIGH    = 12'h008;
  localparam logic [11:0] SLTRG_A_STAT    = 12'h00C;
  localparam logic [11:0] SLTRG_A_CMD     = 12'h010;
  localparam logic [11:0] SLTRG_A_OFFS    = 12'h014;
  localparam logic [11:0] SLTRG_A_GAIN    = 12'h018;
  localparam logic [11:0] SLTRG_A_LAST    = 12'h01C;
  // ctrl field positions
  localparam int          SLTRG_F_MODE    = 0;  // 3 bits
  localparam int          SLTRG_F_CHAN    = 4;  // 3 bits
  localparam int          SLTRG_F_SRC     = 8;  // 2 bits
  localparam int          SLTRG_F_LINE    = 12; // 3 bits
  localparam int          SLTRG_F_TBEXT   = 16;
  localparam int          SLTRG_F_TBDRV   = 17;
  localparam int          SLTRG_F_HOLD    = 18;
  // cmd bits
  localparam int          SLTRG_C_SWTRIG  = 0;
  localparam int          SLTRG_C_ARM     = 1;
  localparam logic [31:0] SLTRG_CTRL_RST  = 32'h0000_0000;
  localparam logic [23:0] SLTRG_THR_RST   = 24'h00_0000;
  localparam logic [23:0] SLTRG_GAIN_ONE  = 24'h40_0000; // 1.0 in q2.22
  localparam int          SLTRG_GAIN_FRAC = 22;
  localparam logic signed [23:0] SLTRG_FS_POS = 24'sh7F_FFFF;
  localparam logic signed [23:0] SLTRG_FS_NEG = -24'sh80_0000;
  // converter latency in tenths of a sample period (model figure only)
  localparam int          SLTRG_LAT_X10   = 388;

  typedef enum logic [2:0] {
    SLTRG_BELOW  = 3'b000,
    SLTRG_ABOVE  = 3'b001,
    SLTRG_INSIDE = 3'b010,
    SLTRG_HYSTH  = 3'b011,
    SLTRG_HYSTL  = 3'b100
  } sltrg_mode_e;

  typedef enum logic [1:0] {
    SLTRG_SRC_SW    = 2'b00,
    SLTRG_SRC_EXT   = 2'b01,
    SLTRG_SRC_LEVEL = 2'b10,
    SLTRG_SRC_LINE  = 2'b11
  } sltrg_src_e;

  typedef struct packed {
    logic                              valid;
    logic [SLTRG_NCH*SLTRG_SW-1:0]     data;
  } sltrg_samples_s;

  typedef struct packed {
    logic                   valid;
    logic signed [23:0]     data;
  } sltrg_cal_s;
endpackage : sltrg_pkg

// [design/sltrg_top.sv]
// sltrg_top: level trigger, trigger routing, timebase select, calibration.
// assumes samples and pins synchronous to i_clk; apb master on i_clk.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module sltrg_top (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [11:0]               i_paddr,
  input  wire logic [31:0]               i_pwdata,
  output logic      [31:0]               o_prdata,
  output logic                           o_pready,
  output logic                           o_pslverr,
  input  wire sltrg_pkg::sltrg_samples_s i_samples,
  input  wire logic                      i_external_trigger_input,
  input  wire logic [7:0]                i_trig_lines,
  output logic                           o_level_trig,
  output logic                           o_start_trig,
  output logic                           o_tb_use_ext,
  output logic                           o_tb_drive_oe,
  output sltrg_pkg::sltrg_cal_s          o_cal
);
  import sltrg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0]        ctrl_r;
  logic signed [23:0] low_threshold_r;
  logic signed [23:0] high_threshold_r;
  logic signed [23:0] offs_r;
  logic [23:0]        gain_r;
  logic               armed_r;
  logic               hyst_ok_r;
  logic               fired_r;
  logic               sw_pulse_r;
  logic signed [23:0] last_r;

  logic               wr_en;
  logic               rd_en;
  logic               arm_cmd;
  logic [2:0]         mode_f;
  logic [2:0]         chan_f;
  logic [1:0]         src_f;
  logic [2:0]         line_f;
  logic signed [23:0] mon;
  logic               qual;
  logic               rearm;
  logic               src_hit;
  logic               line_ok;
  logic               hyst_mode;

  assign wr_en   = i_psel && i_penable && i_pwrite;
  assign rd_en   = i_psel && !i_penable && !i_pwrite;
  assign arm_cmd = wr_en && (i_paddr == SLTRG_A_CMD) &&
                   i_pwdata[SLTRG_C_ARM];
  assign mode_f  = ctrl_r[SLTRG_F_MODE +: 3];
  assign chan_f  = ctrl_r[SLTRG_F_CHAN +: 3];
  assign src_f   = ctrl_r[SLTRG_F_SRC +: 2];
  assign line_f  = ctrl_r[SLTRG_F_LINE +: 3];
  assign hyst_mode = (mode_f == SLTRG_HYSTH) || (mode_f == SLTRG_HYSTL);

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped reads zero with pslverr
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r           <= SLTRG_CTRL_RST;
      low_threshold_r  <= SLTRG_THR_RST;
      high_threshold_r <= SLTRG_THR_RST;
    end else if (wr_en) begin
      unique case (i_paddr)
        SLTRG_A_CTRL: begin
          ctrl_r <= i_pwdata;
          // drive request is dropped while an external timebase is chosen
          ctrl_r[SLTRG_F_TBDRV] <= i_pwdata[SLTRG_F_TBDRV] &&
                                   !i_pwdata[SLTRG_F_TBEXT];
        end
        SLTRG_A_LOW:  low_threshold_r  <= i_pwdata[23:0];
        SLTRG_A_HIGH: high_threshold_r <= i_pwdata[23:0];
        default: ;
      endcase
    end
  end

  // calibration constants live only in flops; host reloads after power-up
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      offs_r <= SLTRG_THR_RST;
      gain_r <= SLTRG_GAIN_ONE;
    end else if (wr_en && i_paddr == SLTRG_A_OFFS) begin
      offs_r <= i_pwdata[23:0];
    end else if (wr_en && i_paddr == SLTRG_A_GAIN) begin
      gain_r <= i_pwdata[23:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      if (i_psel && !i_penable) begin
        unique case (i_paddr)
          SLTRG_A_CTRL: o_prdata <= ctrl_r;
          SLTRG_A_LOW:  o_prdata <= {8'h00, low_threshold_r};
          SLTRG_A_HIGH: o_prdata <= {8'h00, high_threshold_r};
          SLTRG_A_STAT: o_prdata <= {29'h0000_0000, hyst_ok_r,
                                     fired_r, armed_r};
          SLTRG_A_CMD:  o_prdata <= 32'h0000_0000;
          SLTRG_A_OFFS: o_prdata <= {8'h00, offs_r};
          SLTRG_A_GAIN: o_prdata <= {8'h00, gain_r};
          SLTRG_A_LAST: o_prdata <= {8'h00, last_r};
          default:      o_pslverr <= rd_en || i_psel;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // codes reach this compare 38.8 sample periods after the analog event
  // (SLTRG_LAT_X10); the lag is the converter's, none is added here
  // level comparator on the chosen channel; samples pass on unchanged
  assign mon = i_samples.data[chan_f*SLTRG_SW +: SLTRG_SW];

  // full-width signed compares, no truncation
  always_comb begin
    qual  = 1'b0;
    rearm = 1'b0;
    unique case (mode_f)
      SLTRG_BELOW:  qual = mon < low_threshold_r;
      SLTRG_ABOVE:  qual = mon > high_threshold_r;
      SLTRG_INSIDE: qual = (mon > low_threshold_r) &&
                           (mon < high_threshold_r);
      SLTRG_HYSTH: begin
        qual  = mon > high_threshold_r;
        rearm = mon < low_threshold_r;
      end
      SLTRG_HYSTL: begin
        qual  = mon < low_threshold_r;
        rearm = mon > high_threshold_r;
      end
      default: ;
    endcase
  end

  // hysteresis gate: cleared by a trigger, set again by a crossing back
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hyst_ok_r <= 1'b1;
    end else if (i_samples.valid) begin
      if (rearm) begin
        hyst_ok_r <= 1'b1;
      end else if (qual && (mode_f == SLTRG_HYSTH ||
                            mode_f == SLTRG_HYSTL)) begin
        hyst_ok_r <= 1'b0;
      end
    end
  end

  // internal level trigger pulse, one cycle per qualifying sample; the hysteresis modes also need hyst_ok_r set
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_level_trig <= 1'b0;
      last_r       <= SLTRG_THR_RST;
    end else begin
      // a gate closed in a hysteresis mode must not block the plain modes
      o_level_trig <= i_samples.valid && qual &&
                      (hyst_ok_r || !hyst_mode);
      if (i_samples.valid) begin
        last_r <= mon;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source routing; the reserved line never passes even if software picks it
  assign line_ok = (line_f != 3'(SLTRG_RSV_LINE));

  always_comb begin
    src_hit = 1'b0;
    unique case (src_f)
      SLTRG_SRC_SW:    src_hit = sw_pulse_r;
      SLTRG_SRC_EXT:   src_hit = i_external_trigger_input;
      SLTRG_SRC_LEVEL: src_hit = o_level_trig;
      SLTRG_SRC_LINE:  src_hit = line_ok && i_trig_lines[line_f];
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sw_pulse_r <= 1'b0;
    end else begin
      sw_pulse_r <= wr_en && (i_paddr == SLTRG_A_CMD) &&
                    i_pwdata[SLTRG_C_SWTRIG];
    end
  end

  // arm/fire: first hit after arm fires; re-arm clears the held flag
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      armed_r      <= 1'b0;
      fired_r      <= 1'b0;
      o_start_trig <= 1'b0;
    end else begin
      o_start_trig <= 1'b0;
      if (armed_r && src_hit) begin
        armed_r      <= 1'b0;
        fired_r      <= 1'b1;
        o_start_trig <= 1'b1;
      end else if (arm_cmd) begin
        armed_r <= 1'b1;
        fired_r <= 1'b0;
      end
      if (ctrl_r[SLTRG_F_HOLD] && fired_r && !arm_cmd) begin
        o_start_trig <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timebase select and driver
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tb_use_ext  <= 1'b0;
      o_tb_drive_oe <= 1'b0;
    end else begin
      o_tb_use_ext  <= ctrl_r[SLTRG_F_TBEXT];
      o_tb_drive_oe <= ctrl_r[SLTRG_F_TBDRV] &&
                       !ctrl_r[SLTRG_F_TBEXT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // digital calibration of the chosen channel: (x + offset) * gain, clipped
  // to full scale; the trigger still sees raw codes, so thresholds are raw
  logic signed [24:0] cal_sum;
  logic signed [49:0] cal_prod;
  logic signed [49:0] cal_shift;
  assign cal_sum   = 25'(mon) + 25'(offs_r);
  assign cal_prod  = 50'(cal_sum) * $signed({1'b0, 25'(gain_r)});
  assign cal_shift = cal_prod >>> SLTRG_GAIN_FRAC;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cal <= '0;
    end else begin
      o_cal.valid <= i_samples.valid;
      if (cal_shift > 50'(SLTRG_FS_POS)) begin
        o_cal.data <= SLTRG_FS_POS;
      end else if (cal_shift < 50'(SLTRG_FS_NEG)) begin
        o_cal.data <= SLTRG_FS_NEG;
      end else begin
        o_cal.data <= cal_shift[23:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_level_on_valid: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_level_trig |-> $past(i_samples.valid))
    else $error("level trigger without sample valid");
  a_below_mode: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_samples.valid && mode_f == SLTRG_BELOW &&
     mon < low_threshold_r) |=> o_level_trig)
    else $error("below-low sample did not trigger");
  a_above_mode: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_samples.valid && mode_f == SLTRG_ABOVE &&
     !(mon > high_threshold_r)) |=> !o_level_trig)
    else $error("above-high triggered without crossing");
  a_inside_mode: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_samples.valid && mode_f == SLTRG_INSIDE &&
     mon > low_threshold_r && mon < high_threshold_r) |=> o_level_trig)
    else $error("inside sample did not trigger");
  a_hyst_once: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (o_level_trig && !$past(rearm) &&
     $past(mode_f == SLTRG_HYSTH || mode_f == SLTRG_HYSTL)) |-> !hyst_ok_r)
    else $error("hysteresis gate not closed after trigger");
  a_tb_drive: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_tb_drive_oe |-> !o_tb_use_ext)
    else $error("timebase driven while external selected");
  a_rsv_line: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (src_f == SLTRG_SRC_LINE && line_f == 3'(SLTRG_RSV_LINE)) |-> !src_hit)
    else $error("reserved line routed as trigger");
  a_fire_once: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (armed_r && src_hit) |=>
    (!armed_r && fired_r && o_start_trig) ##1 (!armed_r || $past(arm_cmd)))
    else $error("arm not consumed by trigger");
  a_ext_src: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (armed_r && src_f == SLTRG_SRC_EXT && i_external_trigger_input)
    |=> o_start_trig)
    else $error("external trigger not taken");
  a_sw_src: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (armed_r && src_f == SLTRG_SRC_SW && sw_pulse_r) |=> o_start_trig)
    else $error("software trigger not taken");
  a_hold_flag: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (ctrl_r[SLTRG_F_HOLD] && fired_r && !arm_cmd) |=> o_start_trig)
    else $error("held start flag dropped before re-arm");
  a_cal_valid: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_cal.valid |-> $past(i_samples.valid))
    else $error("calibrated word without a new sample");
  c_level_fire: cover property (@(posedge i_clk) disable iff (i_rst)
    armed_r && src_f == SLTRG_SRC_LEVEL && o_level_trig);
  c_sw_fire: cover property (@(posedge i_clk) disable iff (i_rst)
    armed_r && sw_pulse_r && src_f == SLTRG_SRC_SW);
  c_ext_fire: cover property (@(posedge i_clk) disable iff (i_rst)
    armed_r && src_f == SLTRG_SRC_EXT && i_external_trigger_input);
  c_hyst_rearm: cover property (@(posedge i_clk) disable iff (i_rst)
    !hyst_ok_r ##[1:50] hyst_ok_r);
endmodule : sltrg_top

`default_nettype wire

// [dv/sltrg_conv_model.sv]
// sltrg_conv_model: converter output stand-in driving the sample bus.
// assumes the bench raises i_fire for one cycle per new output sample.
`timescale 1ns/10ps
`default_nettype none
module sltrg_conv_model (
  input  wire logic               i_fire,
  input  wire logic [2:0]         i_chan,
  input  wire logic [23:0]        i_code,
  output var sltrg_pkg::sltrg_samples_s o_samples
);
  import sltrg_pkg::*;
  // other channels carry the inverse, so a wrong channel pick shows up
  always_comb begin
    o_samples.valid = i_fire;
    for (int n = 0; n < SLTRG_NCH; n++) begin
      o_samples.data[n*SLTRG_SW +: SLTRG_SW] =
        (n == i_chan) ? i_code : ~i_code;
    end
  end
endmodule : sltrg_conv_model
`default_nettype wire

// [dv/sltrg_tb.sv]
// testbench: apb master plus sample stimulus around sltrg_top.
// assumes one 20 mhz clock and registered apb answers.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module testbench;
  import sltrg_pkg::*;
  logic           clk = 1'b0;
  logic           rst = 1'b1;
  logic           psel = 1'b0;
  logic           penable = 1'b0;
  logic           pwrite = 1'b0;
  logic [11:0]    paddr = 12'h000;
  logic [31:0]    pwdata = 32'h0000_0000;
  logic [31:0]    prdata, rdata;
  logic           pready, pslverr, rerr, lvl_seen;
  logic           fire = 1'b0;
  logic [2:0]     chan = 3'h3;
  logic [23:0]    code = 24'h00_0000;
  logic           ext = 1'b0;
  logic [7:0]     lines = 8'h00;
  logic           level_trig, start_trig, use_ext, drive_oe;
  sltrg_samples_s samples;
  sltrg_cal_s     cal, cal_seen;
  int             err_count = 0;
  int             checks = 0;
  always #25 clk = ~clk;
  sltrg_conv_model model (.i_fire(fire), .i_chan(chan), .i_code(code),
    .o_samples(samples));
  sltrg_top dut (.i_clk(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_samples(samples),
    .i_external_trigger_input(ext), .i_trig_lines(lines),
    .o_level_trig(level_trig), .o_start_trig(start_trig),
    .o_tb_use_ext(use_ext), .o_tb_drive_oe(drive_oe), .o_cal(cal));
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // one idle edge after each transfer keeps psel from two writes per step
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_count++;
      print_verdict();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("rdata", e, rdata)
  endtask : rd_chk
  task automatic samp(input logic v, input logic [23:0] c, input logic e);
    code <= c;
    fire <= v;
    @(posedge clk);
    fire <= 1'b0;
    @(posedge clk);
    lvl_seen = level_trig;
    cal_seen = cal;
    `CHK("level_trig", e, lvl_seen)
  endtask : samp
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK("tb_oe", 1'b0, drive_oe)
    `CHK("tb_ext", 1'b0, use_ext)
    rd_chk(SLTRG_A_CTRL, 32'h0000_0000);
    rd_chk(SLTRG_A_GAIN, 32'h0040_0000);
    rd_chk(SLTRG_A_OFFS, 32'h0000_0000);
    rd_chk(SLTRG_A_STAT, 32'h0000_0004);
    rd_chk(12'h020, 32'h0000_0000);
    `CHK("pslverr", 1'b1, rerr)
  endtask : t_reset
  task automatic t_timebase();
    apb(1'b1, SLTRG_A_CTRL, 32'h0002_0000);
    tick(1);
    `CHK("tb_oe", 1'b1, drive_oe)
    apb(1'b1, SLTRG_A_CTRL, 32'h0003_0000);
    tick(1);
    `CHK("tb_oe", 1'b0, drive_oe)
    `CHK("tb_ext", 1'b1, use_ext)
    rd_chk(SLTRG_A_CTRL, 32'h0001_0000);
  endtask : t_timebase
  task automatic t_modes();
    logic [23:0] tv [5] = '{24'hFF_FF9B, 24'hFF_FF9C, 24'h00_0000,
                            24'h00_0064, 24'h00_0065};
    logic [4:0]  ev [3] = '{5'b00001, 5'b10000, 5'b00100};
    apb(1'b1, SLTRG_A_LOW, 32'h00FF_FF9C);
    apb(1'b1, SLTRG_A_HIGH, 32'h0000_0064);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, SLTRG_A_CTRL, 32'h0000_0030 | m);
      for (int i = 0; i < 5; i++) begin
        samp(1'b1, tv[i], ev[m][i]);
      end
    end
    samp(1'b0, 24'hFF_FF00, 1'b0);
  endtask : t_modes
  task automatic t_hyst();
    apb(1'b1, SLTRG_A_CTRL, 32'h0000_0033);
    samp(1'b1, 24'hFF_FF9B, 1'b0);
    samp(1'b1, 24'h00_0065, 1'b1);
    samp(1'b1, 24'h00_0065, 1'b0);
    samp(1'b1, 24'h00_0000, 1'b0);
    samp(1'b1, 24'hFF_FF9B, 1'b0);
    samp(1'b1, 24'h00_0065, 1'b1);
    apb(1'b1, SLTRG_A_CTRL, 32'h0000_0034);
    samp(1'b1, 24'h00_0065, 1'b0);
    samp(1'b1, 24'hFF_FF9B, 1'b1);
    samp(1'b1, 24'hFF_FF9B, 1'b0);
    samp(1'b1, 24'h00_0065, 1'b0);
    samp(1'b1, 24'hFF_FF9B, 1'b1);
  endtask : t_hyst
  task automatic t_fullscale();
    apb(1'b1, SLTRG_A_CTRL, 32'h0000_0030);
    apb(1'b1, SLTRG_A_LOW, 32'h0080_0001);
    samp(1'b1, SLTRG_FS_NEG, 1'b1);
    samp(1'b1, 24'h80_0001, 1'b0);
    apb(1'b1, SLTRG_A_CTRL, 32'h0000_0031);
    apb(1'b1, SLTRG_A_HIGH, 32'h007F_FFFE);
    samp(1'b1, SLTRG_FS_POS, 1'b1);
    apb(1'b1, SLTRG_A_HIGH, 32'h007F_FFFF);
    samp(1'b1, SLTRG_FS_POS, 1'b0);
  endtask : t_fullscale
  task automatic t_start();
    apb(1'b1, SLTRG_A_LOW, 32'h00FF_FF9C);
    apb(1'b1, SLTRG_A_CTRL, 32'h0004_0230);
    apb(1'b1, SLTRG_A_CMD, 32'h0000_0002);
    samp(1'b1, 24'hFF_FF9B, 1'b1);
    tick(1);
    `CHK("start_lvl", 1'b1, start_trig)
    apb(1'b1, SLTRG_A_CMD, 32'h0000_0002);
    `CHK("start_rearm", 1'b0, start_trig)
    apb(1'b1, SLTRG_A_CTRL, 32'h0000_0030);
    apb(1'b1, SLTRG_A_CMD, 32'h0000_0002);
    apb(1'b1, SLTRG_A_CMD, 32'h0000_0001);
    tick(1);
    `CHK("start_sw", 1'b1, start_trig)
    tick(1);
    `CHK("start_pulse", 1'b0, start_trig)
    apb(1'b1, SLTRG_A_CTRL, 32'h0004_0130);
    apb(1'b1, SLTRG_A_CMD, 32'h0000_0002);
    ext <= 1'b1;
    tick(3);
    ext <= 1'b0;
    `CHK("start_ext", 1'b1, start_trig)
    apb(1'b1, SLTRG_A_CTRL, 32'h0004_5330);
    apb(1'b1, SLTRG_A_CMD, 32'h0000_0002);
    lines <= 8'hFF;
    tick(4);
    `CHK("start_line5", 1'b0, start_trig)
    apb(1'b1, SLTRG_A_CTRL, 32'h0004_3330);
    tick(2);
    lines <= 8'h00;
    `CHK("start_line3", 1'b1, start_trig)
  endtask : t_start
  task automatic t_cal();
    apb(1'b1, SLTRG_A_CTRL, 32'h0000_0031);
    apb(1'b1, SLTRG_A_GAIN, 32'h0020_0000);
    samp(1'b1, 24'h00_03E8, 1'b0);
    `CHK("cal_valid", 1'b1, cal_seen.valid)
    `CHK("cal_half", 24'h00_01F4, cal_seen.data)
    apb(1'b1, SLTRG_A_GAIN, 32'h0040_0000);
    apb(1'b1, SLTRG_A_OFFS, 32'h0000_0005);
    samp(1'b1, 24'h00_03E8, 1'b0);
    `CHK("cal_offs", 24'h00_03ED, cal_seen.data)
    apb(1'b1, SLTRG_A_CTRL, 32'h0002_0000);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
    `CHK("tb_oe_rst", 1'b0, drive_oe)
    rd_chk(SLTRG_A_GAIN, 32'h0040_0000);
    rd_chk(SLTRG_A_OFFS, 32'h0000_0000);
  endtask : t_cal
  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(20);
    rst <= 1'b0;
    tick(1);
    t_reset();
    t_timebase();
    t_modes();
    t_hyst();
    t_fullscale();
    t_start();
    t_cal();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
